// file: verilog/itar_pkg.sv
// Purpose: shared constants and carriers of the i2c target alias remapper
// Assumes: 8-bit register port, 7-bit i2c addresses, eight remote slots
// Notes:   the register port holds the physical slot 7 and alias slots 0-3
//
// Contract
// - match each 7-bit address against every alias
// - on match, forward with that slot's physical address
// - alias slot n pairs with physical slot n
// - zero alias disables its slot entirely
// - auto-ack bit acknowledges writes to that target
// - physical slot 7 bit 0 reads zero
package itar_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] ITAR_OFS_PHYS7  = 8'h40;
  localparam logic [7:0] ITAR_OFS_ALIAS0 = 8'h41;
  localparam logic [7:0] ITAR_OFS_ALIAS1 = 8'h42;
  localparam logic [7:0] ITAR_OFS_ALIAS2 = 8'h43;
  localparam logic [7:0] ITAR_OFS_ALIAS3 = 8'h44;

  // slot organisation
  localparam int ITAR_SLOTS       = 8;
  localparam int ITAR_LOCAL_ALIAS = 4;
  localparam int ITAR_EXT_PHYS    = 7;

  // field layout: id in 7:1, flag or reserved in 0
  localparam int ITAR_ID_MSB = 7;
  localparam int ITAR_ID_LSB = 1;
  localparam int ITAR_FLAG   = 0;

  // reset and special values
  localparam logic [7:0] ITAR_REG_RESET = 8'h00;
  localparam logic [6:0] ITAR_ID_OFF    = 7'h00;
  localparam logic [7:0] ITAR_RD_NONE   = 8'h00;

  // request from the local i2c target decoder
  typedef struct packed {
    logic       valid;  // one-cycle strobe: address byte received
    logic       write;  // transaction direction is write
    logic [6:0] addr;   // 7-bit address seen on the local bus
  } itar_req_type;

  // answer one cycle after the request
  typedef struct packed {
    logic       valid;     // one-cycle strobe
    logic       hit;       // address matched an enabled alias
    logic       auto_ack;  // acknowledge locally, ignore link and remote
    logic [2:0] slot;      // matched slot index
    logic [6:0] phys;      // address to send across the control channel
  } itar_rsp_type;

endpackage

// file: verilog/itar_match.sv
// Purpose: alias comparator bank, lowest matching slot wins
// Assumes: aliases of zero are disabled
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module itar_match #(
  parameter int SLOTS = 8
) (
  input  wire logic [SLOTS-1:0][6:0] alias_id,
  input  wire logic [6:0]            addr,
  output logic                       hit,
  output logic [2:0]                 slot
);

  logic [SLOTS-1:0] eq;  // per-slot match vector

  // elaboration check: the slot index leaving here is three bits wide
  if (SLOTS < 1 || SLOTS > 8)
  begin : g_bad_slots
    $error("itar_match: SLOTS must lie in 1..8");
  end

  // one comparator per slot; a zero alias never matches
  for (genvar i = 0; i < SLOTS; i++)
  begin : g_cmp
    assign eq[i] = (alias_id[i] != itar_pkg::ITAR_ID_OFF) &&
                   (alias_id[i] == addr);
  end

  // priority pick: two slots with the same alias resolve to the lower one
  always_comb
  begin
    hit  = 1'b0;
    slot = 3'h0;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (eq[i])
      begin
        hit  = 1'b1;
        slot = 3'(i);
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/itar_remap.sv
// Purpose: alias registers, physical slot 7 register and address remapping
// Assumes: physical slots 0-6 and alias slots 4-7 live in the neighbouring
//          register file and arrive here as plain inputs
// Notes:   answer one cycle after each request, read data one cycle later
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module itar_remap (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  input  wire itar_pkg::itar_req_type req,
  input  wire logic [6:0][6:0]       ext_phys,
  input  wire logic [3:0][7:0]       ext_alias,
  output var itar_pkg::itar_rsp_type rsp
);

  // software-visible state
  logic [6:0]       phys7;          // physical address for slot 7
  logic [3:0][7:0]  alias_reg;      // alias id in 7:1, auto-ack in 0
  logic [6:0]       next_phys7;
  logic [3:0][7:0]  next_alias_reg;
  logic [7:0]       next_reg_rdata;

  // remap path state
  itar_pkg::itar_rsp_type next_rsp;

  // flattened view of all eight slots
  logic [7:0][6:0] all_alias;  // alias ids, slot order
  logic [7:0]      all_flag;   // auto-ack bits
  logic [7:0][6:0] all_phys;   // physical addresses, slot order
  logic            m_hit;      // comparator bank result
  logic [2:0]      m_slot;

  // gather local and neighbouring slots into one ordered table
  always_comb
  begin
    for (int i = 0; i < itar_pkg::ITAR_SLOTS; i++)
    begin
      if (i < itar_pkg::ITAR_LOCAL_ALIAS)
      begin
        all_alias[i] = alias_reg[i][itar_pkg::ITAR_ID_MSB:
                                    itar_pkg::ITAR_ID_LSB];
        all_flag[i]  = alias_reg[i][itar_pkg::ITAR_FLAG];
      end
      else
      begin
        all_alias[i] = ext_alias[i - itar_pkg::ITAR_LOCAL_ALIAS]
                         [itar_pkg::ITAR_ID_MSB:itar_pkg::ITAR_ID_LSB];
        all_flag[i]  = ext_alias[i - itar_pkg::ITAR_LOCAL_ALIAS]
                         [itar_pkg::ITAR_FLAG];
      end
      // index n of the alias table pairs with index n here
      if (i < itar_pkg::ITAR_EXT_PHYS)
        all_phys[i] = ext_phys[i];
      else
        all_phys[i] = phys7;
    end
  end

  // comparator bank
  itar_match #(
    .SLOTS (itar_pkg::ITAR_SLOTS)
  ) u_match (
    .alias_id (all_alias),
    .addr     (req.addr),
    .hit      (m_hit),
    .slot     (m_slot)
  );

  // register writes; slot 7 keeps only the id field
  always_comb
  begin
    next_phys7     = phys7;
    next_alias_reg = alias_reg;
    if (reg_wr)
    begin
      case (reg_addr)
        itar_pkg::ITAR_OFS_PHYS7:
          next_phys7 = reg_wdata[itar_pkg::ITAR_ID_MSB:
                                 itar_pkg::ITAR_ID_LSB];
        itar_pkg::ITAR_OFS_ALIAS0: next_alias_reg[0] = reg_wdata;
        itar_pkg::ITAR_OFS_ALIAS1: next_alias_reg[1] = reg_wdata;
        itar_pkg::ITAR_OFS_ALIAS2: next_alias_reg[2] = reg_wdata;
        itar_pkg::ITAR_OFS_ALIAS3: next_alias_reg[3] = reg_wdata;
        default:  ; // unmapped writes are dropped
      endcase
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb
  begin
    next_reg_rdata = itar_pkg::ITAR_RD_NONE;
    if (reg_rd)
    begin
      case (reg_addr)
        itar_pkg::ITAR_OFS_PHYS7:
          next_reg_rdata = {phys7, 1'b0};  // reserved bit reads 0
        itar_pkg::ITAR_OFS_ALIAS0: next_reg_rdata = alias_reg[0];
        itar_pkg::ITAR_OFS_ALIAS1: next_reg_rdata = alias_reg[1];
        itar_pkg::ITAR_OFS_ALIAS2: next_reg_rdata = alias_reg[2];
        itar_pkg::ITAR_OFS_ALIAS3: next_reg_rdata = alias_reg[3];
        default:  next_reg_rdata = itar_pkg::ITAR_RD_NONE;
      endcase
    end
  end

  // remap answer; a miss still answers so the decoder can nack
  always_comb
  begin
    next_rsp          = '0;
    next_rsp.valid    = req.valid;
    if (req.valid && m_hit)
    begin
      next_rsp.hit  = 1'b1;
      next_rsp.slot = m_slot;
      next_rsp.phys = all_phys[m_slot];
      // debug aid: acks writes even with the link down, so data may vanish
      next_rsp.auto_ack = req.write && all_flag[m_slot];
    end
  end

  // one register stage for everything; all start cleared
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      phys7     <= itar_pkg::ITAR_ID_OFF;
      alias_reg <= {4{itar_pkg::ITAR_REG_RESET}};
      reg_rdata <= itar_pkg::ITAR_RD_NONE;
      rsp       <= '0;
    end
    else
    begin
      phys7     <= next_phys7;
      alias_reg <= next_alias_reg;
      reg_rdata <= next_reg_rdata;
      rsp       <= next_rsp;
    end
  end

  // previous-cycle copies of the slot tables; a $past of an indexed table
  // would also take the old slot index, so the checks index these instead
  logic [7:0][6:0] chk_alias;  // alias ids seen with the request
  logic [7:0][6:0] chk_phys;   // physical ids seen with the request
  logic [7:0]      chk_flag;   // auto-ack bits seen with the request

  // checker copies only; they feed no output and need no reset
  always_ff @(posedge clk)
  begin
    chk_alias <= all_alias;
    chk_phys  <= all_phys;
    chk_flag  <= all_flag;
  end

  // checks on the remap path and registers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_match_found: assert property (
    req.valid && all_alias[0] != itar_pkg::ITAR_ID_OFF &&
    req.addr == all_alias[0] |=> rsp.valid && rsp.hit && rsp.slot == 3'h0)
    else $error("enabled alias 0 not matched");

  a_miss_clean: assert property (
    req.valid && !m_hit |=> rsp.valid && !rsp.hit && !rsp.auto_ack)
    else $error("miss answered as hit");

  a_phys_subst: assert property (
    rsp.hit |-> rsp.phys == chk_phys[rsp.slot])
    else $error("forwarded address is not the slot address");

  a_slot_pair: assert property (
    rsp.hit |-> $past(req.addr) == chk_alias[rsp.slot])
    else $error("answer slot does not own the matched alias");

  a_zero_off: assert property (
    rsp.hit |-> chk_alias[rsp.slot] != itar_pkg::ITAR_ID_OFF)
    else $error("disabled slot matched");

  a_auto_ack: assert property (
    rsp.valid |-> rsp.auto_ack == (rsp.hit && $past(req.write) &&
                                   chk_flag[rsp.slot]))
    else $error("auto acknowledge wrong");

  a_rsvd_zero: assert property (
    reg_rd && reg_addr == itar_pkg::ITAR_OFS_PHYS7 |=> reg_rdata[0] == 1'b0
    ##0 reg_rdata[7:1] == $past(phys7))
    else $error("slot 7 read wrong");

  a_reset_clear: assert property (disable iff (1'b0)
    !rstn |=> phys7 == itar_pkg::ITAR_ID_OFF && alias_reg == '0 &&
    rsp == '0)
    else $error("state not cleared by reset");

  a_rsp_idle: assert property (
    !req.valid |=> rsp == '0)
    else $error("answer without a request");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == itar_pkg::ITAR_RD_NONE)
    else $error("read data outside its cycle");

  a_phys7_write: assert property (
    reg_wr && reg_addr == itar_pkg::ITAR_OFS_PHYS7 |=>
    phys7 == $past(reg_wdata[itar_pkg::ITAR_ID_MSB:itar_pkg::ITAR_ID_LSB]))
    else $error("slot 7 write lost");

  a_alias_write: assert property (
    reg_wr && reg_addr == itar_pkg::ITAR_OFS_ALIAS0 |=>
    alias_reg[0] == $past(reg_wdata))
    else $error("alias 0 write lost");

  c_hit_write:  cover property (rsp.hit && rsp.auto_ack);
  c_hit_read:   cover property (rsp.hit && !rsp.auto_ack);
  c_miss:       cover property (rsp.valid && !rsp.hit);
  c_back2back:  cover property (reg_wr ##1 reg_rd);
  c_slot7_hit:  cover property (rsp.hit && rsp.slot == 3'h7);

endmodule
`default_nettype wire

// file: tb/itar_ctrl_model.sv
// Purpose: i2c controller model offering address phases
// Assumes: one address phase at a time
// Notes: auto-ack is set by the bench only in debug runs
`timescale 1ns/100ps
`default_nettype none
module itar_ctrl_model (
  input  wire logic                 clk,
  output var itar_pkg::itar_req_type req
);
  // idle until the bench asks for a phase
  initial req = '0;

  // strobe stands one cycle, then the bus goes idle
  task automatic issue(input logic wr_i, input logic [6:0] a);
    @(posedge clk);
    req <= '{valid: 1'b1, write: wr_i, addr: a};
    @(posedge clk);
    req <= '0;
  endtask
endmodule
`default_nettype wire

// file: tb/test_i2c_target_alias_remap.sv
// Purpose: self-checking bench of the alias remapper
// Assumes: 100 MHz clock, reset low six cycles
// Notes:   expectations come from a shadow copy of all slots
`timescale 1ns/100ps
`default_nettype none
module test_i2c_target_alias_remap;
  logic                   clk, rstn;          // clock, reset
  logic [7:0]             reg_addr, reg_wdata; // register port
  logic                   reg_wr, reg_rd;     // strobes
  logic [7:0]             reg_rdata;          // read data
  itar_pkg::itar_req_type req;                // address phase
  logic [6:0][6:0]        ext_phys;           // physical slots 0-6
  logic [3:0][7:0]        ext_alias;          // alias slots 4-7
  itar_pkg::itar_rsp_type rsp;                // remap answer
  logic [7:0]             al [8];             // shadow alias bytes
  logic [6:0]             ph [8];             // shadow physical ids
  int                     miscompares, comparisons;
  logic [7:0]             d;                  // random byte
  logic [6:0]             gone [4];           // local ids before reset

  itar_remap itar_remap_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req(req), .ext_phys(ext_phys),
    .ext_alias(ext_alias), .rsp(rsp));
  itar_ctrl_model itar_ctrl_model_inst (.clk(clk), .req(req));

  // 10 ns clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [12:0] seen,
                       input logic [12:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check("rdata", {5'h00, reg_rdata}, {5'h00, exp});
  endtask

  // expected answer; scanning downwards lets the lowest slot win
  function automatic itar_pkg::itar_rsp_type want(logic w, logic [6:0] a);
    itar_pkg::itar_rsp_type r;
    r = '0;
    r.valid = 1'b1;
    for (int n = 7; n >= 0; n--)
      if (al[n][7:1] != 7'h00 && al[n][7:1] == a)
      begin
        r.hit      = 1'b1;
        r.slot     = 3'(n);
        r.phys     = ph[n];
        r.auto_ack = w & al[n][0];
      end
    return r;
  endfunction

  // one address phase, answer looked at in its single cycle
  task automatic probe(input logic w, input logic [6:0] a);
    itar_ctrl_model_inst.issue(w, a);
    #1 check("rsp", rsp, want(w, a));
  endtask

  // main sequence
  initial
  begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_phys = '0;
    ext_alias = '0;
    miscompares = 0;
    comparisons = 0;
    for (int n = 0; n < 8; n++)
    begin
      al[n] = 8'h00;
      ph[n] = 7'h00;
    end
    void'($urandom(56061));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // reset values, 0x45 being unmapped
    for (int k = 0; k < 6; k++)
      rd(8'h40 + 8'(k), 8'h00);
    probe(1'b1, 7'h00);
    repeat (20)
    begin
      for (int n = 0; n < 8; n++)
      begin
        d = 8'($urandom);
        // this is a debug run, so auto-ack bits stay random
        al[n] = ($urandom % 4 == 0) ? {7'h00, d[0]} : d;
        ph[n] = 7'($urandom);
      end
      for (int n = 0; n < 4; n++)
        wr(8'h41 + 8'(n), al[n]);
      wr(8'h40, {ph[7], 1'b1});
      wr(8'h45, 8'hff);
      for (int n = 0; n < 7; n++)
        ext_phys[n] <= ph[n];
      for (int n = 0; n < 4; n++)
        ext_alias[n] <= al[n + 4];
      rd(8'h40, {ph[7], 1'b0});
      for (int n = 0; n < 4; n++)
        rd(8'h41 + 8'(n), al[n]);
      for (int n = 0; n < 8; n++)
        probe(1'($urandom), al[n][7:1]);
      probe(1'b1, 7'($urandom));
      probe(1'b1, 7'h00);
    end
    // reset in mid-run: local slots clear, neighbouring ones stay
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int n = 0; n < 4; n++)
    begin
      gone[n] = al[n][7:1];
      al[n]   = 8'h00;
    end
    ph[7] = 7'h00;
    for (int k = 0; k < 5; k++)
      rd(8'h40 + 8'(k), 8'h00);
    for (int n = 0; n < 4; n++)
      probe(1'b1, gone[n]);
    give_verdict;
  end

  // cut a hang short after 10000 cycles
  initial
  begin
    #100000;
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
